/* File: logic/dac_refresh_loopback_sequencer.sv */
`timescale 1ns/1ns
module dac_refresh_loopback_sequencer
  import dac_seq_pkg::*;
#(
  parameter logic [15:0] BOARD_ID          = 16'h00a5, // Arbitrary value
  parameter int          CONV_SETTLE_TICKS = ceil_ticks(CONV_SETTLE_NS)
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Backplane pins, asynchronous to clk_i
  input  wire logic        sysclk_i,
  input  wire logic        sel_i,
  input  wire logic        ds0_n_i,
  input  wire logic        ds1_n_i,
  input  wire logic        write_n_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [15:0] d_i,
  output      logic [15:0] d_o,
  output      logic        d_oe_n_o,
  output      logic        dtack_o,
  output      logic        dtack_oe_n_o,
  // Shared DAC and distributor
  output      logic [11:0] dac_code_o,
  output      logic        dac_load_o,
  output      logic [4:0]  dist_sel_o,
  output      logic [3:0]  dist_group_en_o,
  output      logic        dist_en_o,
  // Output switches and front LED
  output      logic        out_switch_o,
  output      logic        led_o,
  // Loopback monitor and ADC
  output      logic [4:0]  mon_chan_o,
  output      logic        adc_track_o,
  output      logic        adc_start_o,
  input  wire logic [11:0] adc_data_i
);

  typedef struct packed {
    bus_pins_t                pin_s1;
    bus_pins_t                pin_s2;
    logic                     clk_s1;
    logic                     clk_s2;
    logic                     clk_s3;
    logic [11:0]              adc_s1;
    logic [11:0]              adc_s2;
    logic [31:0][WORD_W-1:0]  mem;
    bus_st_t                  bus_st;
    logic                     rd;
    logic [15:0]              rdata;
    seq_st_t                  seq_st;
    logic [4:0]               chan;
    logic [10:0]              seq_cnt;
    logic [11:0]              dac_code;
    logic                     dac_load;
    conv_st_t                 conv_st;
    logic [16:0]              conv_cnt;
    logic [4:0]               mon_chan;
    logic                     adc_start;
    logic [11:0]              result;
    logic                     ready;
    ctl_t                     ctl;
  } state_t;

  state_t      cur_ff;
  state_t      nxt_ff;
  bus_pins_t   pins;
  bus_pins_t   p;
  logic        strobe;
  logic        bus_req;
  logic        tick;
  logic        freeze;
  logic        seq_reading;
  logic        host_go;
  logic        conv_go;
  logic        track_next;
  logic [10:0] hold_ticks;
  logic [15:0] status;

  // Byte lanes: DS1 carries D15..D8, DS0 carries D7..D0
  function automatic logic [15:0] merge_bytes(input logic [15:0] old_w,
                                              input logic [15:0] new_w,
                                              input logic        ds0_n,
                                              input logic        ds1_n);
    logic [15:0] w;
    w = old_w;
    if (!ds1_n) begin
      w[15:8] = new_w[15:8];
    end
    if (!ds0_n) begin
      w[7:0] = new_w[7:0];
    end
    return w;
  endfunction

  assign pins    = '{sel: sel_i, ds0_n: ds0_n_i, ds1_n: ds1_n_i,
                     write_n: write_n_i, addr: addr_i, wdata: d_i};
  assign p       = cur_ff.pin_s2;
  assign strobe  = !p.ds0_n || !p.ds1_n;
  assign bus_req = p.sel && strobe;
  assign tick    = cur_ff.clk_s2 && !cur_ff.clk_s3;
  assign freeze  = cur_ff.conv_st inside {C_TRACK, C_CONVERT};
  // Entering track would race a load at the same edge
  assign track_next  = tick && cur_ff.conv_st == C_SETTLE &&
                       cur_ff.conv_cnt == '0;
  assign conv_go     = cur_ff.bus_st == B_IDLE && bus_req && !p.write_n &&
                       p.addr == REG_CSR_IDX && p.wdata[CSR_CONV_BIT] &&
                       p.wdata[CSR_SETTLE_BIT];
  assign seq_reading = cur_ff.seq_st == S_LOAD && !freeze && !track_next;
  assign host_go     = cur_ff.bus_st == B_WAIT && !seq_reading;
  assign hold_ticks  = cur_ff.ctl.fast ? 11'(HOLD_FAST_TICKS - 1)
                                       : 11'(HOLD_NORM_TICKS - 1);

  // Trigger bits read back as busy flags
  always_comb begin
    status                 = '0;
    status[4:0]            = cur_ff.mon_chan;
    status[CSR_CONV_BIT]   = cur_ff.conv_st != C_IDLE;
    status[CSR_SETTLE_BIT] = cur_ff.conv_st inside {C_SETTLE, C_TRACK};
    status[CSR_FAST_BIT]   = cur_ff.ctl.fast;
    status[CSR_TWOS_BIT]   = cur_ff.ctl.twos;
    status[CSR_SWITCH_BIT] = cur_ff.ctl.switch_on;
    status[CSR_LED_BIT]    = cur_ff.ctl.led;
    status[CSR_READY_BIT]  = cur_ff.ready;
  end

  always_comb begin
    nxt_ff           = cur_ff;
    nxt_ff.pin_s1    = pins;
    nxt_ff.pin_s2    = cur_ff.pin_s1;
    nxt_ff.clk_s1    = sysclk_i;
    nxt_ff.clk_s2    = cur_ff.clk_s1;
    nxt_ff.clk_s3    = cur_ff.clk_s2;
    nxt_ff.adc_s1    = adc_data_i;
    nxt_ff.adc_s2    = cur_ff.adc_s1;
    nxt_ff.dac_load  = 1'b0;
    nxt_ff.adc_start = 1'b0;

    unique case (cur_ff.bus_st)
      B_IDLE: begin
        if (bus_req) begin
          nxt_ff.rd = p.write_n;
          if (p.addr[CHAN_BASE_BIT]) begin
            nxt_ff.bus_st = B_WAIT;
          end else begin
            nxt_ff.bus_st = B_ACK;
            nxt_ff.rdata  = '0;
            if (p.write_n) begin
              unique case (p.addr)
                REG_ID_IDX:  nxt_ff.rdata = BOARD_ID;
                REG_CSR_IDX: nxt_ff.rdata = status;
                REG_ADC_IDX: begin
                  nxt_ff.rdata = {4'h0, cur_ff.result};
                  nxt_ff.ready = 1'b0;
                end
                default:     nxt_ff.rdata = '0;
              endcase
            end else if (p.addr == REG_CSR_IDX) begin
              nxt_ff.ctl.fast      = p.wdata[CSR_FAST_BIT];
              nxt_ff.ctl.twos      = p.wdata[CSR_TWOS_BIT];
              nxt_ff.ctl.switch_on = p.wdata[CSR_SWITCH_BIT];
              nxt_ff.ctl.led       = p.wdata[CSR_LED_BIT];
            end
          end
        end
      end
      B_WAIT: begin
        if (host_go) begin
          nxt_ff.bus_st = B_ACK;
          if (cur_ff.rd) begin
            nxt_ff.rdata = cur_ff.mem[p.addr[4:0]];
          end else begin
            nxt_ff.mem[p.addr[4:0]] = merge_bytes(cur_ff.mem[p.addr[4:0]],
                                                  p.wdata, p.ds0_n, p.ds1_n);
          end
        end
      end
      B_ACK: begin
        if (!strobe) begin
          nxt_ff.bus_st = B_IDLE;
        end
      end
      default: nxt_ff.bus_st = B_IDLE;
    endcase

    if (!freeze && !track_next) begin
      unique case (cur_ff.seq_st)
        S_LOAD: begin
          nxt_ff.dac_code = cur_ff.mem[cur_ff.chan][CODE_W-1:0];
          nxt_ff.dac_load = 1'b1;
          nxt_ff.seq_cnt  = 11'(DAC_SET_TICKS - 1);
          nxt_ff.seq_st   = S_SETTLE;
        end
        S_SETTLE: begin
          if (tick) begin
            if (cur_ff.seq_cnt == '0) begin
              nxt_ff.seq_st  = S_HOLD;
              nxt_ff.seq_cnt = hold_ticks;
            end else begin
              nxt_ff.seq_cnt = cur_ff.seq_cnt - 11'h001;
            end
          end
        end
        S_HOLD: begin
          if (tick) begin
            if (cur_ff.seq_cnt == '0) begin
              // Five-bit counter wraps 31 to 0
              nxt_ff.chan   = cur_ff.chan + 5'h01;
              nxt_ff.seq_st = S_LOAD;
            end else begin
              nxt_ff.seq_cnt = cur_ff.seq_cnt - 11'h001;
            end
          end
        end
        default: nxt_ff.seq_st = S_LOAD;
      endcase
    end

    if (conv_go) begin
      // A restart wins over a phase change in the same cycle
      nxt_ff.conv_st  = C_SETTLE;
      nxt_ff.conv_cnt = 17'(CONV_SETTLE_TICKS - 1);
      nxt_ff.mon_chan = p.wdata[4:0];
      nxt_ff.ready    = 1'b0;
    end else if (tick && cur_ff.conv_st != C_IDLE) begin
      if (cur_ff.conv_cnt != '0) begin
        nxt_ff.conv_cnt = cur_ff.conv_cnt - 17'h00001;
      end else begin
        unique case (cur_ff.conv_st)
          C_SETTLE: begin
            nxt_ff.conv_st  = C_TRACK;
            nxt_ff.conv_cnt = 17'(TRACK_TICKS - 1);
          end
          C_TRACK: begin
            nxt_ff.conv_st   = C_CONVERT;
            nxt_ff.conv_cnt  = 17'(CONVERT_TICKS - 1);
            nxt_ff.adc_start = 1'b1;
          end
          C_CONVERT: begin
            nxt_ff.conv_st = C_IDLE;
            nxt_ff.result  = cur_ff.adc_s2 ^
                             (cur_ff.ctl.twos ? TWOS_FLIP : 12'h000);
            // Set wins over a read clear
            nxt_ff.ready   = 1'b1;
          end
          default: nxt_ff.conv_st = C_IDLE;
        endcase
      end
    end
  end

  // System reset clears timers and flags
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign d_o             = cur_ff.rdata;
  assign d_oe_n_o        = !(cur_ff.bus_st == B_ACK && cur_ff.rd);
  assign dtack_o         = 1'b0;
  assign dtack_oe_n_o    = cur_ff.bus_st != B_ACK;
  assign dac_code_o      = cur_ff.dac_code;
  assign dac_load_o      = cur_ff.dac_load;
  // Same five bits select the hold stage
  assign dist_sel_o      = cur_ff.chan;
  // Demux enabled only in the hold interval
  assign dist_en_o       = cur_ff.seq_st == S_HOLD && !freeze;
  assign dist_group_en_o = dist_en_o ? 4'(4'h1 << cur_ff.chan[4:3]) : 4'h0;
  assign out_switch_o    = cur_ff.ctl.switch_on;
  assign led_o           = cur_ff.ctl.led;
  assign mon_chan_o      = cur_ff.mon_chan;
  assign adc_track_o     = cur_ff.conv_st == C_TRACK;
  assign adc_start_o     = cur_ff.adc_start;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  dac_from_mem_a: assert property (
    seq_reading |=> dac_load_o && !$past(freeze)
      && dac_code_o == $past(cur_ff.mem[cur_ff.chan][CODE_W-1:0]))
    else $error("DAC code not taken from channel word");

  chan_order_a: assert property (
    cur_ff.seq_st == S_HOLD && nxt_ff.seq_st == S_LOAD
      |=> dist_sel_o == 5'($past(cur_ff.chan) + 5'h01) ##1 dac_load_o)
    else $error("Channel did not advance in order");

  group_sel_a: assert property (
    dist_en_o |-> dist_group_en_o[cur_ff.chan[4:3]] &&
      $onehot(dist_group_en_o))
    else $error("Demux group does not match channel");

  one_port_a: assert property (
    host_go |-> !seq_reading ##1 !dac_load_o && cur_ff.bus_st == B_ACK)
    else $error("Both memory ports active together");

  freeze_hold_a: assert property (
    freeze |=> $stable(cur_ff.seq_cnt) && $stable(cur_ff.chan)
      && !$past(dac_load_o && freeze))
    else $error("Sequencer moved during conversion");

  conv_start_a: assert property (
    cur_ff.bus_st == B_IDLE && bus_req && !p.write_n &&
      p.addr == REG_CSR_IDX && p.wdata[CSR_CONV_BIT] &&
      p.wdata[CSR_SETTLE_BIT]
      |=> cur_ff.conv_st == C_SETTLE && mon_chan_o == $past(p.wdata[4:0])
        && !cur_ff.ready)
    else $error("Control write did not start conversion");

  conv_order_a: assert property (
    cur_ff.conv_st == C_TRACK && nxt_ff.conv_st != C_TRACK && !conv_go
      |=> cur_ff.conv_st == C_CONVERT && adc_start_o)
    else $error("Conversion phases out of order");

  ready_set_a: assert property (
    cur_ff.conv_st == C_CONVERT && nxt_ff.conv_st == C_IDLE
      |=> cur_ff.ready && status[CSR_READY_BIT])
    else $error("Data ready not set after conversion");

  hold_len_a: assert property (
    cur_ff.seq_st == S_SETTLE && nxt_ff.seq_st == S_HOLD
      |=> cur_ff.seq_cnt == ($past(cur_ff.ctl.fast) ? 11'(HOLD_FAST_TICKS - 1)
                                             : 11'(HOLD_NORM_TICKS - 1)))
    else $error("Hold interval length wrong for scan mode");

endmodule // dac_refresh_loopback_sequencer

/* File: logic/dac_seq_pkg.sv */
package dac_seq_pkg;
  localparam int NUM_CH     = 32;
  localparam int CODE_W     = 12;
  localparam int WORD_W     = 16;
  // Backplane timer clock in MHz, seen as a tick enable
  localparam int TICK_MHZ   = 16;

  // Least times round up to whole ticks
  function automatic int ceil_ticks(input int ns);
    return (ns * TICK_MHZ + 999) / 1000;
  endfunction

  localparam int SCAN_NORM_NS    = 3400000;
  localparam int SCAN_FAST_NS    = 850000;
  localparam int DAC_SETTLE_NS   = 2000;
  localparam int CONV_SETTLE_NS  = 5000000;
  localparam int TRACK_NS        = 2000;
  localparam int CONVERT_NS      = 13000;
  // Channel slot is a period, so it rounds down
  localparam int SLOT_NORM_TICKS = SCAN_NORM_NS * TICK_MHZ / 1000 / NUM_CH;
  localparam int SLOT_FAST_TICKS = SCAN_FAST_NS * TICK_MHZ / 1000 / NUM_CH;
  localparam int DAC_SET_TICKS   = ceil_ticks(DAC_SETTLE_NS);
  localparam int HOLD_NORM_TICKS = SLOT_NORM_TICKS - DAC_SET_TICKS;
  localparam int HOLD_FAST_TICKS = SLOT_FAST_TICKS - DAC_SET_TICKS;
  localparam int TRACK_TICKS     = ceil_ticks(TRACK_NS);
  localparam int CONVERT_TICKS   = ceil_ticks(CONVERT_NS);

  // Word indices on address lines A06..A01
  localparam logic [5:0] REG_ID_IDX  = 6'h00;
  localparam logic [5:0] REG_CSR_IDX = 6'h01;
  localparam logic [5:0] REG_ADC_IDX = 6'h02;
  localparam int CHAN_BASE_BIT = 5;

  localparam int CSR_CONV_BIT   = 8;
  localparam int CSR_SETTLE_BIT = 9;
  localparam int CSR_FAST_BIT   = 10;
  localparam int CSR_TWOS_BIT   = 11;
  localparam int CSR_SWITCH_BIT = 12;
  localparam int CSR_LED_BIT    = 13;
  localparam int CSR_READY_BIT  = 14;
  localparam logic [11:0] TWOS_FLIP = 12'h800;

  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_ACK} bus_st_t;
  typedef enum logic [1:0] {S_LOAD, S_SETTLE, S_HOLD} seq_st_t;
  typedef enum logic [1:0] {C_IDLE, C_SETTLE, C_TRACK, C_CONVERT} conv_st_t;

  typedef struct packed {
    logic        sel;
    logic        ds0_n;
    logic        ds1_n;
    logic        write_n;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } bus_pins_t;

  typedef struct packed {
    logic fast;
    logic twos;
    logic switch_on;
    logic led;
  } ctl_t;
endpackage

/* File: test/bus_host_model.sv */
`timescale 1ns/1ns
module bus_host_model
  import dac_seq_pkg::*;
(
  // Board answer
  input  wire logic        clk_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        d_oe_n_i,
  input  wire logic        ack_n_i,
  // Bus pins
  output      bus_pins_t   pins_o
);
  initial pins_o = '{1'b0, 1'b1, 1'b1, 1'b1, 6'h3f, 16'h5a5a};

  // Request stands until ack is seen, released on the next edge
  task automatic cycle(input logic [5:0] idx, input logic wr,
                       input logic [1:0] ln, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ok);
    int n;
    @(posedge clk_i);
    pins_o <= '{1'b1, ~ln[0], ~ln[1], ~wr, idx, wr ? wd : ~pins_o.wdata};
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_n_i !== 1'b0 && n < 50);
    // Undriven data lines read back inverted
    rd = d_oe_n_i ? ~rd_data_i : rd_data_i;
    ok = n < 50;
    @(posedge clk_i);
    pins_o <= '{1'b0, 1'b1, 1'b1, 1'b1, ~idx, ~pins_o.wdata};
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_n_i !== 1'b1 && n < 50);
    ok = ok && n < 50;
  endtask
endmodule // bus_host_model

/* File: test/dac_refresh_loopback_sequencer_test.sv */
`timescale 1ns/1ns
module dac_refresh_loopback_sequencer_test
  import dac_seq_pkg::*;
;
  // Arbitrary identity value
  localparam logic [15:0] ID_VAL = 16'h00c3;
  logic        clk_i      = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        sysclk_i   = 1'b0;
  logic [11:0] adc_data_i = 12'h000;
  bus_pins_t   pins;
  logic [15:0] d_o;
  logic        d_oe_n_o, dtack_oe_n_o, dac_load_o, dist_en_o;
  logic        out_switch_o, led_o, adc_track_o, adc_start_o;
  logic [11:0] dac_code_o;
  logic [4:0]  dist_sel_o, mon_chan_o;
  logic [3:0]  dist_group_en_o, grp;
  logic [15:0] mem [32];
  int          failures   = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          frz_cnt    = 0;
  int          frz_bad    = 0;

  dac_refresh_loopback_sequencer #(
    .BOARD_ID          (ID_VAL),
    .CONV_SETTLE_TICKS (20)
  ) DUT (
    .clk_i, .sys_rst_i, .sysclk_i,
    .sel_i     (pins.sel),
    .ds0_n_i   (pins.ds0_n),
    .ds1_n_i   (pins.ds1_n),
    .write_n_i (pins.write_n),
    .addr_i    (pins.addr),
    .d_i       (pins.wdata),
    .d_o, .d_oe_n_o, .dtack_o (), .dtack_oe_n_o,
    .dac_code_o, .dac_load_o, .dist_sel_o, .dist_group_en_o,
    .dist_en_o, .out_switch_o, .led_o, .mon_chan_o,
    .adc_track_o, .adc_start_o, .adc_data_i
  );

  bus_host_model HOST (
    .clk_i, .rd_data_i (d_o), .d_oe_n_i (d_oe_n_o),
    .ack_n_i (dtack_oe_n_o), .pins_o (pins)
  );

  initial forever #2 clk_i = ~clk_i;
  // Backplane clock sped up to 4 cycles a tick; counts stay in ticks
  initial forever #8 sysclk_i = ~sysclk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  assign grp = dist_en_o ? 4'h1 << dist_sel_o[4:3] : 4'h0;

  always @(negedge clk_i) begin
    if (adc_start_o) frz_cnt <= CONVERT_TICKS * 4 - 8;
    else if (frz_cnt > 0) frz_cnt <= frz_cnt - 1;
    if ((adc_track_o || frz_cnt > 0) && (dac_load_o || dist_en_o))
      frz_bad <= frz_bad + 1;
    if (!sys_rst_i) chk("group", {12'h0, grp}, {12'h0, dist_group_en_o});
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic [5:0] idx, input logic wr,
                     input logic [1:0] ln, input logic [15:0] wd,
                     output logic [15:0] rd);
    logic ok;
    HOST.cycle(idx, wr, ln, wd, rd, ok);
    chk("ack", 16'h1, {15'h0, ok});
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] wd,
                    input logic [1:0] ln = 2'b11);
    logic [15:0] r;
    bus(idx, 1'b1, ln, wd, r);
  endtask

  task automatic rd_chk(input string what, input logic [5:0] idx,
                        input logic [15:0] exp);
    logic [15:0] r;
    bus(idx, 1'b0, 2'b11, 16'h0, r);
    chk(what, exp, r);
  endtask

  task automatic wait_load(output int t);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (dac_load_o !== 1'b1 && n < 8000);
    t = cyc;
    chk("load seen", 16'h1, {15'h0, n < 8000});
  endtask

  task automatic poll_ready(output logic [15:0] r);
    int n;
    n = 0;
    do begin
      repeat (100) @(posedge clk_i);
      bus(REG_CSR_IDX, 1'b0, 2'b11, 16'h0, r);
      n++;
    end while (r[CSR_READY_BIT] !== 1'b1 && n < 40);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_reset();
    @(posedge clk_i) sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("idle oe", 16'h3, {14'h0, d_oe_n_o, dtack_oe_n_o});
    @(posedge clk_i) sys_rst_i <= 1'b0;
    @(negedge clk_i);
    chk("outs", 16'h0, {12'h0, out_switch_o, led_o, adc_track_o, dist_en_o});
    rd_chk("csr", REG_CSR_IDX, 16'h0);
    rd_chk("adc", REG_ADC_IDX, 16'h0);
    rd_chk("id", REG_ID_IDX, ID_VAL);
    $display("t_reset done");
  endtask

  task automatic t_conv();
    int n;
    int w;
    logic [15:0] r;
    @(posedge clk_i) adc_data_i <= 12'h3c5;
    wr(REG_CSR_IDX, 16'h1100);
    n = 0;
    repeat (300) @(negedge clk_i) if (adc_track_o) n++;
    chk("lone trigger", 16'h0, 16'(n));
    chk("switch", 16'h1, {15'h0, out_switch_o});
    wr(REG_CSR_IDX, 16'h1b07);
    rd_chk("csr busy", REG_CSR_IDX, 16'h1b07);
    chk("mon chan", 16'h7, {11'h0, mon_chan_o});
    n = 0;
    while (adc_track_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    w = 0;
    while (adc_track_o === 1'b1 && w < 300) begin
      @(negedge clk_i);
      w++;
    end
    chk("track", 16'(TRACK_TICKS * 4), 16'(w));
    poll_ready(r);
    chk("csr ready", 16'h5807, r);
    chk("frozen", 16'h0, 16'(frz_bad));
    rd_chk("result", REG_ADC_IDX, {4'h0, 12'h3c5 ^ TWOS_FLIP});
    rd_chk("ready off", REG_CSR_IDX, 16'h1807);
    wr(REG_CSR_IDX, 16'h3b01);
    $display("t_conv done");
  endtask

  task automatic t_mem();
    for (int i = 0; i < 32; i++) begin
      mem[i] = 16'h8000 ^ 16'(i * 16'h0123);
      wr(6'h20 + 6'(i), mem[i]);
    end
    for (int i = 0; i < 32; i++) rd_chk("word", 6'h20 + 6'(i), mem[i]);
    wr(6'h26, 16'hab00, 2'b10);
    wr(6'h25, 16'h00cd, 2'b01);
    mem[6][15:8] = 8'hab;
    mem[5][7:0] = 8'hcd;
    rd_chk("high lane", 6'h26, mem[6]);
    rd_chk("low lane", 6'h25, mem[5]);
    rd_chk("unmapped", 6'h03, 16'h0);
    wr(REG_ID_IDX, 16'hffff);
    rd_chk("id kept", REG_ID_IDX, ID_VAL);
    $display("t_mem done");
  endtask

  task automatic t_scan();
    int t0;
    int t;
    int n;
    logic [4:0] c;
    logic [4:0] nx;
    wait_load(t0);
    chk("first chan", 16'h1, {11'h0, dist_sel_o});
    n = 0;
    while (dist_en_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk("dac settle", 16'h1, {15'h0, n inside {[124:132]}});
    wait_load(t);
    chk("slot", 16'h1, {15'h0, (t - t0) inside {[6796:6808]}});
    wr(REG_CSR_IDX, 16'h1400);
    wait_load(t);
    c = 5'h03;
    repeat (30) begin
      t0 = t;
      c++;
      wait_load(t);
      chk("order", {11'h0, c}, {11'h0, dist_sel_o});
      chk("code", {4'h0, mem[c][11:0]}, {4'h0, dac_code_o});
      chk("fast", 16'h1, {15'h0, (t - t0) inside {[1696:1708]}});
      nx = c + 5'h1;
      mem[nx] = ~mem[nx];
      wr(6'h20 + 6'(nx), mem[nx]);
    end
    $display("t_scan done");
  endtask

  task automatic t_self();
    int n;
    logic [15:0] r;
    wr(6'h23, 16'h0a5c);
    // Loop back only after the channel was refreshed
    n = 0;
    while (!(dist_en_o === 1'b1 && dist_sel_o === 5'h03) && n < 8000) begin
      @(negedge clk_i);
      n++;
    end
    chk("refresh seen", 16'h1, {15'h0, n < 8000});
    // Monitor path sees the held level of the channel
    @(posedge clk_i) adc_data_i <= dac_code_o;
    // Binary code with twos bit clear
    wr(REG_CSR_IDX, 16'h1703);
    poll_ready(r);
    chk("self ready", 16'h5403, r);
    rd_chk("self test", REG_ADC_IDX, 16'h0a5c);
    chk("frozen", 16'h0, 16'(frz_bad));
    $display("t_self done");
  endtask

  initial begin
    // Whole run is about 72k cycles
    repeat (95000) @(posedge clk_i);
    failures++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    t_reset();
    t_conv();
    t_reset();
    t_mem();
    t_scan();
    t_self();
    end_of_test();
  end
endmodule // dac_refresh_loopback_sequencer_test
